// *** pkg/fwg_pkg.sv ***
// Behaviour
// - data-move writes program, code-move reads return bytes
// - 128-byte scratchpad sector at 0x8000..0x807F
// - byte programming only clears bits until erase
// - main sectors are 512 bytes, erased whole
// - write enable bit 0 gates software modification; debug write/erase ignore it
// - erase enable plus write enable erases page
// - each lock bit guards one 4k block
// - cleared read-lock bit blocks debug reads
// - cleared write-lock bit blocks debug write/erase
// - software may write, never erase lock sector
package fwg_pkg;
    // apb register byte offsets
    localparam logic [7:0]  FWG_OFS_CTRL   = 8'h00;
    localparam logic [7:0]  FWG_OFS_STATUS = 8'h04;
    // control and status field positions, control reset value
    localparam int          FWG_BIT_WE     = 0;
    localparam int          FWG_BIT_EE     = 1;
    localparam int          FWG_BIT_REFUSE = 1;
    localparam logic [7:0]  FWG_CTRL_RST   = 8'h00;
    // flash geometry
    localparam logic [15:0] FWG_SCR_BASE   = 16'h8000;
    localparam logic [15:0] FWG_SCR_LAST   = 16'h807F;
    localparam int          FWG_MEM_BYTES  = 32896;
    localparam logic [8:0]  FWG_BIG_LAST   = 9'h1FF;
    localparam logic [8:0]  FWG_SCR_CNT    = 9'h07F;
    localparam logic [15:0] FWG_RDLOCK_AD  = 16'h7DFF;
    localparam logic [15:0] FWG_WRLOCK_AD  = 16'h7DFE;
    localparam logic [6:0]  FWG_LOCK_SECT  = 7'h3E;
    localparam logic [7:0]  FWG_ERASED     = 8'hFF;
    // debug-side operations
    localparam logic [1:0]  FWG_OP_READ    = 2'h0;
    localparam logic [1:0]  FWG_OP_WRITE   = 2'h1;
    localparam logic [1:0]  FWG_OP_ERASE   = 2'h2;
    // erase sequencer states
    typedef enum logic {
        FWG_ST_IDLE  = 1'b0,
        FWG_ST_ERASE = 1'b1
    } fwg_state_t;
endpackage

// *** hw/fwg_flash_guard.sv ***
`timescale 1ns/1ps
module fwg_flash_guard
    import fwg_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // software data-move write port
    input  wire logic        cpu_xwr_valid,
    input  wire logic [15:0] cpu_xwr_addr,
    input  wire logic [7:0]  cpu_xwr_data,
    output logic             cpu_xwr_ready,
    output logic             cpu_xwr_done,
    output logic             cpu_xwr_refused,
    // software code-move read port
    input  wire logic        cpu_crd_valid,
    input  wire logic [15:0] cpu_crd_addr,
    output logic [7:0]       cpu_crd_data,
    output logic             cpu_crd_done,
    // debug access port
    input  wire logic        jtag_req,
    input  wire logic [1:0]  jtag_op,
    input  wire logic [15:0] jtag_addr,
    input  wire logic [7:0]  jtag_wdata,
    output logic             jtag_ready,
    output logic [7:0]       jtag_rdata,
    output logic             jtag_done,
    output logic             jtag_denied,
    // status
    output logic             busy
);
    // flash array, erased state at power-up
    logic [7:0]  mem [FWG_MEM_BYTES] = '{default: FWG_ERASED};
    // control and status
    logic [7:0]  program_store_control;
    logic        refused_flag;
    fwg_state_t  state;
    // erase sequencer
    logic [15:0] er_addr;
    logic [8:0]  er_cnt;
    logic        er_jtag;
    // decode terms
    logic        flash_write_enable;
    logic        flash_erase_enable;
    logic [7:0]  rd_lock;
    logic [7:0]  wr_lock;
    logic        cpu_take;
    logic        cpu_ok;
    logic        cpu_erase;
    logic        jtag_take;
    logic        jtag_ok;
    logic        er_start;
    logic        er_small;
    logic [15:0] er_src;
    logic        prog_en;
    logic [15:0] prog_addr;
    logic [7:0]  prog_data;
    logic [7:0]  prog_old;
    logic [7:0]  crd_peek;
    logic        apb_wr;
    logic        apb_setup;
    // erase length as seen by the checks
    logic [9:0]  len_cnt;
    logic        len_small;

    // checks sample on the rising edge, idle during reset
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // address within array
    function automatic logic addr_ok(input logic [15:0] a);
        return a <= FWG_SCR_LAST;
    endfunction

    // lock bit for a block; scratchpad lies outside the locks
    function automatic logic blk_open(input logic [7:0] lk,
                                      input logic [15:0] a);
        return a[15] ? 1'b1 : lk[a[14:12]];
    endfunction

    // first byte of the sector holding an address
    function automatic logic [15:0] sect_base(input logic [15:0] a);
        return a[15] ? FWG_SCR_BASE : {a[15:9], 9'h000};
    endfunction

    // enable bits and lock bytes
    assign flash_write_enable = program_store_control[FWG_BIT_WE];
    assign flash_erase_enable = program_store_control[FWG_BIT_EE];
    assign rd_lock = mem[FWG_RDLOCK_AD];
    assign wr_lock = mem[FWG_WRLOCK_AD];
    assign busy    = (state == FWG_ST_ERASE);

    // request acceptance; software write has priority
    assign cpu_xwr_ready = !busy;
    assign jtag_ready    = !busy && !cpu_xwr_valid;
    assign cpu_take      = cpu_xwr_valid && !busy;
    assign jtag_take     = jtag_req && jtag_ready;
    assign cpu_erase     = flash_erase_enable;

    // software write checks
    always_comb begin
        cpu_ok = addr_ok(cpu_xwr_addr) && flash_write_enable;
        if (cpu_erase && cpu_xwr_addr[15:9] == FWG_LOCK_SECT) begin
            cpu_ok = 1'b0;
        end
    end

    // debug access checks against lock bytes
    always_comb begin
        jtag_ok = addr_ok(jtag_addr);
        if (jtag_op == FWG_OP_READ) begin
            jtag_ok = jtag_ok && blk_open(rd_lock, jtag_addr);
        end else if (jtag_op == FWG_OP_WRITE
                     || jtag_op == FWG_OP_ERASE) begin
            jtag_ok = jtag_ok && blk_open(wr_lock, jtag_addr);
        end else begin
            jtag_ok = 1'b0;
        end
    end

    // erase start and source address
    assign er_start = (cpu_take && cpu_ok && cpu_erase)
                   || (jtag_take && jtag_ok && jtag_op == FWG_OP_ERASE);
    assign er_src   = cpu_take ? cpu_xwr_addr : jtag_addr;
    assign er_small = er_src[15];

    // byte programming source
    always_comb begin
        prog_en   = 1'b0;
        prog_addr = cpu_xwr_addr;
        prog_data = cpu_xwr_data;
        if (cpu_take && cpu_ok && !cpu_erase) begin
            prog_en = 1'b1;
        end else if (jtag_take && jtag_ok
                     && jtag_op == FWG_OP_WRITE) begin
            prog_en   = 1'b1;
            prog_addr = jtag_addr;
            prog_data = jtag_wdata;
        end
    end
    assign prog_old = mem[prog_addr];
    assign crd_peek = mem[cpu_crd_addr];

    // array update: erase fills, programming only clears bits
    always_ff @(posedge pclk) begin
        if (busy) begin
            mem[er_addr] <= FWG_ERASED;
        end else if (prog_en) begin
            mem[prog_addr] <= prog_old & prog_data;
        end
    end

    // erase sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= FWG_ST_IDLE;
            er_addr <= 16'h0000;
            er_cnt  <= 9'h000;
            er_jtag <= 1'b0;
        end else if (state == FWG_ST_IDLE) begin
            if (er_start) begin
                state   <= FWG_ST_ERASE;
                er_addr <= sect_base(er_src);
                // scratch sector 128 bytes, others 512
                er_cnt  <= er_small ? FWG_SCR_CNT : FWG_BIG_LAST;
                er_jtag <= !cpu_take;
            end
        end else begin
            er_addr <= er_addr + 16'h0001;
            er_cnt  <= er_cnt - 9'h001;
            if (er_cnt == 9'h000) begin
                state <= FWG_ST_IDLE;
            end
        end
    end

    // software write answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_xwr_done    <= 1'b0;
            cpu_xwr_refused <= 1'b0;
        end else begin
            cpu_xwr_done    <= (cpu_take && cpu_ok && !cpu_erase)
                            || (busy && er_cnt == 9'h000 && !er_jtag);
            cpu_xwr_refused <= cpu_take && !cpu_ok;
        end
    end

    // code-move read, one cycle latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_crd_data <= 8'h00;
            cpu_crd_done <= 1'b0;
        end else begin
            cpu_crd_done <= cpu_crd_valid;
            if (cpu_crd_valid) begin
                cpu_crd_data <= crd_peek;
            end
        end
    end

    // debug answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jtag_rdata  <= 8'h00;
            jtag_done   <= 1'b0;
            jtag_denied <= 1'b0;
        end else begin
            jtag_denied <= jtag_take && !jtag_ok;
            jtag_done   <= (jtag_take && jtag_ok
                            && jtag_op != FWG_OP_ERASE)
                        || (busy && er_cnt == 9'h000 && er_jtag);
            if (jtag_take && jtag_ok && jtag_op == FWG_OP_READ) begin
                jtag_rdata <= mem[jtag_addr];
            end
        end
    end

    // apb phases
    assign pready    = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite;

    // control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_store_control <= FWG_CTRL_RST;
        end else if (apb_wr && paddr == FWG_OFS_CTRL) begin
            // unused bits read as zero
            program_store_control <= {6'h00, pwdata[1:0]};
        end
    end

    // sticky refusal flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_flag <= 1'b0;
        end else if (cpu_take && !cpu_ok) begin
            refused_flag <= 1'b1;
        end else if (apb_wr && paddr == FWG_OFS_STATUS
                     && pwdata[FWG_BIT_REFUSE]) begin
            refused_flag <= 1'b0;
        end
    end

    // read data and error captured in setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            unique case (paddr)
                FWG_OFS_CTRL: begin
                    prdata  <= {24'h00_0000, program_store_control};
                    pslverr <= 1'b0;
                end
                FWG_OFS_STATUS: begin
                    prdata  <= {8'h00, wr_lock, rd_lock, 6'h00,
                                refused_flag, busy};
                    pslverr <= 1'b0;
                end
                default: begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // erase length counted apart from the sequencer's own counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_cnt   <= 10'h000;
            len_small <= 1'b0;
        end else if (er_start) begin
            // new erase: restart count, note sector kind
            len_cnt   <= 10'h000;
            len_small <= er_small;
        end else if (busy) begin
            len_cnt <= len_cnt + 10'h001;
        end
    end

    // checks
    a_write_gated: assert property (
        cpu_take && !flash_write_enable
        |=> cpu_xwr_refused && !cpu_xwr_done && !busy)
        else $error("write accepted with write enable low");
    a_no_erase_off: assert property (
        !flash_write_enable && !jtag_take |-> !er_start)
        else $error("erase started with write enable low");
    a_prog_clears: assert property (
        prog_en && !busy
        |=> mem[$past(prog_addr)]
            == ($past(prog_old) & $past(prog_data)))
        else $error("programming set a bit");
    a_big_sector: assert property (
        $fell(busy) && !len_small
        |-> len_cnt == {1'b0, FWG_BIG_LAST} + 10'h001)
        else $error("main sector erase length wrong");
    a_erase_bound: assert property (
        busy |-> len_cnt <= {1'b0, FWG_BIG_LAST})
        else $error("erase ran past a main sector");
    a_scr_sector: assert property (
        er_start && er_small |=> busy ##127 busy ##1 !busy)
        else $error("scratch sector erase length wrong");
    a_erase_fill: assert property (
        busy |=> mem[$past(er_addr)] == FWG_ERASED)
        else $error("erase left a byte programmed");
    a_lock_erase: assert property (
        cpu_take && cpu_erase && cpu_xwr_addr[15:9] == FWG_LOCK_SECT
        |=> cpu_xwr_refused && !busy)
        else $error("lock sector erased by software");
    a_rd_locked: assert property (
        jtag_take && jtag_op == FWG_OP_READ
        && !blk_open(rd_lock, jtag_addr)
        |=> jtag_denied && !jtag_done)
        else $error("locked block read over debug");
    a_wr_locked: assert property (
        jtag_take && jtag_op != FWG_OP_READ
        && !blk_open(wr_lock, jtag_addr)
        |=> jtag_denied && !busy)
        else $error("locked block altered over debug");
    a_code_read: assert property (
        cpu_crd_valid
        |=> cpu_crd_done && cpu_crd_data == $past(crd_peek))
        else $error("code read returned wrong byte");
    c_erase_done: cover property (busy ##1 !busy);
    c_jtag_deny: cover property (jtag_denied);
    c_prog_byte: cover property (cpu_xwr_done && !busy);
    c_scr_erase: cover property (er_start && er_small);
    c_jtag_erase: cover property (busy && er_jtag ##1 jtag_done);
endmodule

// *** test/fwg_debug_host.sv ***
`timescale 1ns/1ps
module fwg_debug_host (
    // clock
    input  wire logic        pclk,
    // debug port of the guard
    output logic             jtag_req,
    output logic [1:0]       jtag_op,
    output logic [15:0]      jtag_addr,
    output logic [7:0]       jtag_wdata,
    input  wire logic        jtag_ready,
    input  wire logic        jtag_done,
    input  wire logic        jtag_denied
);
    // idle: no request, lines hold no useful value
    initial begin
        jtag_req   = 1'b0;
        jtag_op    = 2'h3;
        jtag_addr  = 16'hFFFF;
        jtag_wdata = 8'h00;
    end
    // one access; request held until the guard is ready at an edge
    task automatic run(input logic [1:0] op, input logic [15:0] a,
                       input logic [7:0] d, output logic [1:0] res);
        int n;
        @(posedge pclk);
        jtag_req   <= 1'b1;
        jtag_op    <= op;
        jtag_addr  <= a;
        jtag_wdata <= d;
        do @(posedge pclk); while (jtag_ready !== 1'b1);
        jtag_req   <= 1'b0;
        jtag_addr  <= ~a;
        jtag_wdata <= ~d;
        // answer: next cycle, or at the end of an erase
        n = 0;
        @(negedge pclk);
        while (jtag_done !== 1'b1 && jtag_denied !== 1'b1 && n < 600) begin
            n++;
            @(negedge pclk);
        end
        res = {jtag_denied, jtag_done};
    endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
    import fwg_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, busy;
    logic        xv = 1'b0, cv = 1'b0;
    logic [15:0] xa = 16'h0000, ca = 16'h0000, ja;
    logic [7:0]  xd = 8'h00, cd, jrd, jwd;
    logic        xrdy, xdone, xref, cdone, jreq, jrdy, jdone, jden;
    logic [1:0]  jop, r;
    int          n_fail = 0, tests_run = 0, cyc = 0, nb;

    fwg_flash_guard u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_xwr_valid(xv), .cpu_xwr_addr(xa),
        .cpu_xwr_data(xd), .cpu_xwr_ready(xrdy), .cpu_xwr_done(xdone),
        .cpu_xwr_refused(xref), .cpu_crd_valid(cv), .cpu_crd_addr(ca),
        .cpu_crd_data(cd), .cpu_crd_done(cdone), .jtag_req(jreq),
        .jtag_op(jop), .jtag_addr(ja), .jtag_wdata(jwd),
        .jtag_ready(jrdy), .jtag_rdata(jrd), .jtag_done(jdone),
        .jtag_denied(jden), .busy(busy));
    fwg_debug_host u_host (.pclk(pclk), .jtag_req(jreq), .jtag_op(jop),
        .jtag_addr(ja), .jtag_wdata(jwd), .jtag_ready(jrdy),
        .jtag_done(jdone), .jtag_denied(jden));

    // clock and hang guard
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // data-move write; nb counts busy cycles of an erase
    task automatic xwr(input logic [15:0] a, input logic [7:0] d);
        @(posedge pclk);
        xv <= 1'b1;
        xa <= a;
        xd <= d;
        do @(posedge pclk); while (xrdy !== 1'b1);
        xv <= 1'b0;
        @(negedge pclk);
        r = {xref, xdone};
        nb = 0;
        while (busy === 1'b1 && nb < 600) begin
            nb++;
            // both request ports closed while erasing
            if (nb == 1) begin
                chk({xrdy, jrdy}, 2'b00);
            end
            r[0] = r[0] | xdone;
            @(negedge pclk);
        end
        r[0] = r[0] | xdone;
    endtask
    task automatic crd(input logic [15:0] a);
        @(posedge pclk);
        cv <= 1'b1;
        ca <= a;
        @(posedge pclk);
        cv <= 1'b0;
        @(negedge pclk);
        chk({31'h0, cdone}, 32'h0000_0001);
    endtask

    task automatic t_regs();
        apb(1'b0, FWG_OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk({xrdy, jrdy, pready}, 3'b111);
        xwr(16'h1234, 8'h00);
        chk(r, 2'b10);
        crd(16'h1234);
        chk(cd, 8'hFF);
        $display("regs and guard done");
    endtask
    task automatic t_prog();
        apb(1'b1, FWG_OFS_CTRL, 32'h0000_0001);
        xwr(16'h1234, 8'hA5);
        chk(r, 2'b01);
        crd(16'h1234);
        chk(cd, 8'hA5);
        xwr(16'h1234, 8'h5A);
        crd(16'h1234);
        chk(cd, 8'h00);
        xwr(16'h807F, 8'h00);
        chk(r, 2'b01);
        xwr(16'h8080, 8'h00);
        chk(r, 2'b10);
        $display("program done");
    endtask
    task automatic t_erase();
        apb(1'b1, FWG_OFS_CTRL, 32'h0000_0003);
        xwr(16'h13FF, 8'h00);
        chk(nb, 512);
        crd(16'h1234);
        chk(cd, 8'hFF);
        xwr(16'h8000, 8'h00);
        xwr(16'h8040, 8'h12);
        chk(nb, 128);
        chk(r, 2'b01);
        crd(16'h8000);
        chk(cd, 8'hFF);
        crd(16'h807F);
        chk(cd, 8'hFF);
        apb(1'b1, FWG_OFS_STATUS, 32'h0000_0002);
        apb(1'b0, FWG_OFS_STATUS, 32'h0000_0000);
        chk(rd[1:0], 2'b00);
        xwr(16'h7C10, 8'h00);
        chk(r, 2'b10);
        apb(1'b0, FWG_OFS_STATUS, 32'h0000_0000);
        chk(rd[1], 1'b1);
        apb(1'b1, FWG_OFS_CTRL, 32'h0000_0001);
        xwr(16'h8040, 8'h3C);
        crd(16'h8040);
        chk(cd, 8'h3C);
        $display("erase done");
    endtask
    task automatic t_lock();
        xwr(FWG_RDLOCK_AD, 8'hFE);
        chk(r, 2'b01);
        xwr(FWG_WRLOCK_AD, 8'hFD);
        apb(1'b0, FWG_OFS_STATUS, 32'h0000_0000);
        chk(rd[23:8], 16'hFDFE);
        u_host.run(FWG_OP_READ, 16'h0100, 8'h00, r);
        chk(r, 2'b10);
        u_host.run(FWG_OP_READ, 16'h1000, 8'h00, r);
        chk(r, 2'b01);
        chk(jrd, 8'hFF);
        u_host.run(FWG_OP_WRITE, 16'h1000, 8'h00, r);
        chk(r, 2'b10);
        u_host.run(FWG_OP_ERASE, 16'h1000, 8'h00, r);
        chk(r, 2'b10);
        u_host.run(FWG_OP_WRITE, 16'h2000, 8'h66, r);
        crd(16'h2000);
        chk(cd, 8'h66);
        u_host.run(2'h3, 16'h2000, 8'h00, r);
        chk(r, 2'b10);
        u_host.run(FWG_OP_ERASE, 16'h2000, 8'h00, r);
        chk(r, 2'b01);
        crd(16'h2000);
        chk(cd, 8'hFF);
        $display("locks done");
    endtask
    task automatic t_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FWG_OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, FWG_OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h00FD_FE00);
        crd(16'h8040);
        chk(cd, 8'h3C);
        $display("reset done");
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_prog();
        t_erase();
        t_lock();
        t_reset();
        complete_run();
    end
endmodule
